// file: design/fcsp_pkg.sv
package fcsp_pkg;

    // ------------------------------------------------------------
    // Slot layout
    // ------------------------------------------------------------
    localparam int SLOT_TOT_FIRST = 5;
    localparam int TOT_COUNT = 3;
    localparam int SLOT_COMP_FIRST = 8;
    localparam int SLOT_DSTATE_FIRST = 10;
    localparam int SLOT_DCMD_FIRST = 12;
    localparam int PAY_ENTRIES = 128;

    // ------------------------------------------------------------
    // Byte positions inside a payload
    // ------------------------------------------------------------
    localparam int TOT_CTRL_IDX = 0;
    localparam int TOT_MODE_IDX = 1;
    localparam int FLOAT_STATUS_IDX = 4;
    localparam int DISC_VAL_IDX = 0;
    localparam int DISC_STAT_IDX = 1;

    // ------------------------------------------------------------
    // Code sets
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FCSP_MODE_BOTH = 2'b00,
        FCSP_MODE_POS = 2'b01,
        FCSP_MODE_NEG = 2'b10,
        FCSP_MODE_HALT = 2'b11
    } fcsp_mode_e;

    localparam logic [7:0] MODE_MAX = 8'h03;
    localparam logic [7:0] CTRL_CONTINUE = 8'h00;
    localparam logic [7:0] CTRL_CLEAR = 8'h01;
    localparam logic [7:0] CTRL_PRESET = 8'h02;
    localparam logic [7:0] CMD_OFF = 8'h00;
    localparam logic [7:0] CMD_ON = 8'h01;
    localparam logic [7:0] STATUS_GOOD = 8'h80;
    localparam logic [7:0] STATUS_BAD = 8'h00;

    // ------------------------------------------------------------
    // Channel numbers
    // ------------------------------------------------------------
    localparam logic [15:0] CH_SWITCH = 16'h037D;
    localparam logic [15:0] CH_EMPTY_PIPE = 16'h037E;
    localparam logic [15:0] CH_LOW_FLOW = 16'h037F;
    localparam logic [15:0] CH_VERIFY = 16'h0596;
    localparam logic [15:0] CH_DENSITY = 16'h02DB;
    localparam logic [15:0] CH_EXT_TEMP = 16'h0133;
    localparam logic [15:0] CH_OVERRIDE = 16'h037B;
    localparam logic [15:0] CH_VERIFY_START = 16'h0595;

    // ------------------------------------------------------------
    // APB register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_DSTATE1_CH = 8'h00;
    localparam logic [7:0] REG_DSTATE2_CH = 8'h04;
    localparam logic [7:0] REG_SW_ADDR = 8'h08;
    localparam logic [7:0] REG_ADDR_STAT = 8'h0C;
    localparam logic [7:0] REG_MODE_STAT = 8'h10;
    localparam logic [7:0] REG_COMP_CH = 8'h14;
    localparam logic [7:0] REG_DCMD_CH = 8'h18;
    localparam logic [6:0] SW_ADDR_RESET = 7'h7E;
    localparam logic [6:0] SW_ADDR_MAX = 7'h7E;

endpackage : fcsp_pkg

// file: design/fcsp_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Totalizer slot takes control and mode bytes, returns total and status.
// - Mode 0 both directions, 1 positive, 2 negative, 3 halt.
// - After reset all three totalizers run in mode 0.
// - Three totalizer payloads occupy slots five to seven.
// - Two compensation payloads occupy slots eight and nine.
// - First compensation is external density, second external temperature.
// - Discrete state payload is state byte then status byte.
// - Two discrete state payloads occupy slots ten and eleven.
// - Channel selector picks switch, empty pipe, low flow or verify.
// - State byte reads 0 inactive, 1 active.
// - Two discrete command payloads occupy slots twelve and thirteen.
// - First command drives flow override, second starts verification.
// - Command 0 disables the function, 1 enables it.
// - Software address writes ignored while hardware addressing is active.
// - Control 0 continues, 1 clears total, 2 loads preset.
module fcsp_top
    import fcsp_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Cyclic exchange
    input wire logic dx_wr,
    input wire logic [3:0] dx_slot,
    input wire logic [2:0] dx_idx,
    input wire logic [7:0] dx_wdata,
    input wire logic dx_commit,
    input wire logic dx_rd,
    output logic [7:0] dx_rdata,
    output logic dx_rvalid,
    // Totalizers
    input wire logic [2:0][31:0] tot_value,
    input wire logic [2:0][7:0] tot_status,
    output logic [2:0][1:0] total_count_mode,
    output logic [2:0] tot_clear,
    output logic [2:0] tot_preset,
    // Compensation outputs
    output logic [31:0] dens_value,
    output logic [7:0] dens_status,
    output logic [31:0] ext_temp_value,
    output logic [7:0] ext_temp_status,
    // Device functions
    input wire logic switch_state,
    input wire logic empty_pipe,
    input wire logic low_flow_cut,
    input wire logic verify_result,
    output logic flow_override,
    output logic verify_start,
    // Bus address
    input wire logic hw_addr_sel,
    input wire logic [6:0] hw_addr,
    output logic [6:0] bus_address
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [6:0] pay_addr(input int slot, input int idx);
        return 7'(slot * 8 + idx);
    endfunction : pay_addr

    function automatic logic [8:0] dstate_pick(input logic [15:0] ch,
        input logic [3:0] fn);
        case (ch)
            CH_SWITCH: dstate_pick = {1'b1, 7'h00, fn[0]};
            CH_EMPTY_PIPE: dstate_pick = {1'b1, 7'h00, fn[1]};
            CH_LOW_FLOW: dstate_pick = {1'b1, 7'h00, fn[2]};
            CH_VERIFY: dstate_pick = {1'b1, 7'h00, fn[3]};
            default: dstate_pick = 9'h000;
        endcase
    endfunction : dstate_pick

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_n;
    logic rst_q_n;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_n <= 1'b0;
            rst_q_n <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_q_n <= rst_meta_n;
        end
    end

    // ------------------------------------------------------------
    // Payload buffers
    // ------------------------------------------------------------
    logic [7:0] stage [0:PAY_ENTRIES-1];
    logic [7:0] snap [0:PAY_ENTRIES-1];
    logic [1:0][15:0] dsel;
    logic [6:0] sw_addr;
    logic [3:0] fn_state;
    logic [8:0] pick0;
    logic [8:0] pick1;

    function automatic logic [31:0] float_at(input int slot);
        return {stage[pay_addr(slot, 0)], stage[pay_addr(slot, 1)],
            stage[pay_addr(slot, 2)], stage[pay_addr(slot, 3)]};
    endfunction : float_at

    assign fn_state = {verify_result, low_flow_cut, empty_pipe, switch_state};
    assign pick0 = dstate_pick(dsel[0], fn_state);
    assign pick1 = dstate_pick(dsel[1], fn_state);

    // Output bytes from the master collect here until commit
    always_ff @(posedge sys_clk or negedge rst_q_n)
    begin
        if (!rst_q_n)
        begin
            for (int i = 0; i < PAY_ENTRIES; i++)
                stage[i] <= 8'h00;
        end
        else if (dx_wr)
        begin
            stage[{dx_slot, dx_idx}] <= dx_wdata;
        end
    end

    // Input payloads refreshed as one set at commit
    always_ff @(posedge sys_clk or negedge rst_q_n)
    begin
        if (!rst_q_n)
        begin
            for (int i = 0; i < PAY_ENTRIES; i++)
                snap[i] <= 8'h00;
        end
        else if (dx_commit)
        begin
            for (int t = 0; t < TOT_COUNT; t++)
            begin
                for (int b = 0; b < 4; b++)
                    snap[pay_addr(SLOT_TOT_FIRST + t, b)] <=
                        tot_value[t][31-8*b -: 8];
                snap[pay_addr(SLOT_TOT_FIRST + t, FLOAT_STATUS_IDX)] <=
                    tot_status[t];
            end
            snap[pay_addr(SLOT_DSTATE_FIRST, DISC_VAL_IDX)] <= pick0[7:0];
            snap[pay_addr(SLOT_DSTATE_FIRST, DISC_STAT_IDX)] <=
                pick0[8] ? STATUS_GOOD : STATUS_BAD;
            snap[pay_addr(SLOT_DSTATE_FIRST + 1, DISC_VAL_IDX)] <= pick1[7:0];
            snap[pay_addr(SLOT_DSTATE_FIRST + 1, DISC_STAT_IDX)] <=
                pick1[8] ? STATUS_GOOD : STATUS_BAD;
        end
    end

    // Input payload read port
    always_ff @(posedge sys_clk or negedge rst_q_n)
    begin
        if (!rst_q_n)
        begin
            dx_rvalid <= 1'b0;
            dx_rdata <= 8'h00;
        end
        else
        begin
            dx_rvalid <= dx_rd;
            dx_rdata <= dx_rd ? snap[{dx_slot, dx_idx}] : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Totalizer control and mode
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_q_n)
    begin
        if (!rst_q_n)
        begin
            total_count_mode <= {3{FCSP_MODE_BOTH}};
            tot_clear <= 3'h0;
            tot_preset <= 3'h0;
        end
        else
        begin
            for (int t = 0; t < TOT_COUNT; t++)
            begin
                tot_clear[t] <= dx_commit &&
                    stage[pay_addr(SLOT_TOT_FIRST + t, TOT_CTRL_IDX)]
                    == CTRL_CLEAR;
                tot_preset[t] <= dx_commit &&
                    stage[pay_addr(SLOT_TOT_FIRST + t, TOT_CTRL_IDX)]
                    == CTRL_PRESET;
                if (dx_commit &&
                    stage[pay_addr(SLOT_TOT_FIRST + t, TOT_MODE_IDX)]
                    <= MODE_MAX)
                    total_count_mode[t] <=
                        stage[pay_addr(SLOT_TOT_FIRST + t, TOT_MODE_IDX)][1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Compensation values
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_q_n)
    begin
        if (!rst_q_n)
        begin
            dens_value <= 32'h0000_0000;
            dens_status <= 8'h00;
            ext_temp_value <= 32'h0000_0000;
            ext_temp_status <= 8'h00;
        end
        else if (dx_commit)
        begin
            dens_value <= float_at(SLOT_COMP_FIRST);
            dens_status <= stage[pay_addr(SLOT_COMP_FIRST, FLOAT_STATUS_IDX)];
            ext_temp_value <= float_at(SLOT_COMP_FIRST + 1);
            ext_temp_status <=
                stage[pay_addr(SLOT_COMP_FIRST + 1, FLOAT_STATUS_IDX)];
        end
    end

    // ------------------------------------------------------------
    // Discrete commands
    // ------------------------------------------------------------
    logic [7:0] cmd0;
    logic [7:0] cmd1;

    assign cmd0 = stage[pay_addr(SLOT_DCMD_FIRST, DISC_VAL_IDX)];
    assign cmd1 = stage[pay_addr(SLOT_DCMD_FIRST + 1, DISC_VAL_IDX)];

    always_ff @(posedge sys_clk or negedge rst_q_n)
    begin
        if (!rst_q_n)
        begin
            flow_override <= 1'b0;
            verify_start <= 1'b0;
        end
        else if (dx_commit)
        begin
            if (cmd0 == CMD_ON || cmd0 == CMD_OFF)
                flow_override <= cmd0[0];
            if (cmd1 == CMD_ON || cmd1 == CMD_OFF)
                verify_start <= cmd1[0];
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    logic [31:0] rd_data;
    logic rd_err;
    logic apb_wr;

    assign apb_wr = psel && penable && pready && pwrite;

    always_comb
    begin
        rd_err = 1'b0;
        case (paddr)
            REG_DSTATE1_CH: rd_data = {16'h0000, dsel[0]};
            REG_DSTATE2_CH: rd_data = {16'h0000, dsel[1]};
            REG_SW_ADDR: rd_data = {25'h0000000, sw_addr};
            REG_ADDR_STAT: rd_data = {23'h000000, hw_addr_sel, 1'b0,
                bus_address};
            REG_MODE_STAT: rd_data = {26'h0000000, total_count_mode};
            REG_COMP_CH: rd_data = {CH_EXT_TEMP, CH_DENSITY};
            REG_DCMD_CH: rd_data = {CH_VERIFY_START, CH_OVERRIDE};
            default:
            begin
                rd_data = 32'h0000_0000;
                rd_err = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_q_n)
    begin
        if (!rst_q_n)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && penable && !pready;
            prdata <= (psel && penable && !pready && !pwrite) ?
                rd_data : 32'h0000_0000;
            pslverr <= psel && penable && !pready && rd_err;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_q_n)
    begin
        if (!rst_q_n)
        begin
            dsel[0] <= CH_EMPTY_PIPE;
            dsel[1] <= CH_LOW_FLOW;
        end
        else if (apb_wr && paddr == REG_DSTATE1_CH)
            dsel[0] <= pwdata[15:0];
        else if (apb_wr && paddr == REG_DSTATE2_CH)
            dsel[1] <= pwdata[15:0];
    end

    always_ff @(posedge sys_clk or negedge rst_q_n)
    begin
        if (!rst_q_n)
        begin
            sw_addr <= SW_ADDR_RESET;
            bus_address <= SW_ADDR_RESET;
        end
        else
        begin
            if (apb_wr && paddr == REG_SW_ADDR && !hw_addr_sel
                && pwdata[6:0] <= SW_ADDR_MAX && pwdata[31:7] == 25'h0)
                sw_addr <= pwdata[6:0];
            bus_address <= hw_addr_sel ? hw_addr : sw_addr;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [7:0] mode0_b;
    logic [7:0] ctrl0_b;
    logic [7:0] snap_rd;
    logic [7:0] snap_ds0;

    assign mode0_b = stage[pay_addr(SLOT_TOT_FIRST, TOT_MODE_IDX)];
    assign ctrl0_b = stage[pay_addr(SLOT_TOT_FIRST, TOT_CTRL_IDX)];
    assign snap_rd = snap[{dx_slot, dx_idx}];
    assign snap_ds0 = snap[pay_addr(SLOT_DSTATE_FIRST, DISC_VAL_IDX)];

    sequence apb_access_s;
        psel && !penable ##1 psel && penable;
    endsequence

    sequence commit_clear_s;
        dx_commit && ctrl0_b == CTRL_CLEAR;
    endsequence

    mode_after_reset_a: assert property (@(posedge sys_clk)
        $rose(rst_q_n) |-> total_count_mode == '0)
        else $error("totalizer mode not zero after reset");

    mode_decode_a: assert property (@(posedge sys_clk)
        disable iff (!rst_q_n)
        dx_commit && mode0_b <= MODE_MAX |=>
            total_count_mode[0] == $past(mode0_b[1:0]))
        else $error("totalizer mode not taken from payload");

    mode_hold_a: assert property (@(posedge sys_clk)
        disable iff (!rst_q_n)
        !dx_commit |=> $stable(total_count_mode))
        else $error("totalizer mode changed outside commit");

    clear_pulse_a: assert property (@(posedge sys_clk)
        disable iff (!rst_q_n)
        commit_clear_s |=> tot_clear[0] && !tot_preset[0])
        else $error("clear code did not pulse clear");

    comp_pass_a: assert property (@(posedge sys_clk)
        disable iff (!rst_q_n)
        dx_commit |=> dens_value == $past(float_at(SLOT_COMP_FIRST)))
        else $error("density value altered on its way out");

    dstate_map_a: assert property (@(posedge sys_clk)
        disable iff (!rst_q_n)
        dx_commit && dsel[0] == CH_EMPTY_PIPE |=>
            snap_ds0 == {7'h00, $past(empty_pipe)})
        else $error("discrete state byte wrong");

    dcmd_on_a: assert property (@(posedge sys_clk)
        disable iff (!rst_q_n)
        dx_commit && cmd0 == CMD_ON |=> flow_override ##0 !tot_clear[2] ||
            flow_override)
        else $error("command one did not enable override");

    addr_lock_a: assert property (@(posedge sys_clk)
        disable iff (!rst_q_n)
        hw_addr_sel |=> $stable(sw_addr))
        else $error("software address changed under hardware select");

    apb_answer_a: assert property (@(posedge sys_clk)
        disable iff (!rst_q_n)
        apb_access_s |=> pready ##1 !pready)
        else $error("apb answer not one cycle after access");

    read_port_a: assert property (@(posedge sys_clk)
        disable iff (!rst_q_n)
        dx_rd && !dx_commit |=> dx_rvalid && dx_rdata == $past(snap_rd))
        else $error("payload read returned wrong byte");

endmodule : fcsp_top

// file: bench/fcsp_master_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Cyclic master model
// ------------------------------------------------------------
module fcsp_master_model
    import fcsp_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Exchange requests
    output logic dx_wr,
    output logic [3:0] dx_slot,
    output logic [2:0] dx_idx,
    output logic [7:0] dx_wdata,
    output logic dx_commit,
    output logic dx_rd,
    // Exchange answers
    input wire logic [7:0] dx_rdata,
    input wire logic dx_rvalid
);
    initial
    begin
        dx_wr = 1'b0;
        dx_slot = 4'h0;
        dx_idx = 3'h0;
        dx_wdata = 8'h00;
        dx_commit = 1'b0;
        dx_rd = 1'b0;
    end

    // Data line shows the inverse once released
    task wr_byte(input logic [3:0] s, input logic [2:0] i,
                 input logic [7:0] d);
        @(posedge sys_clk);
        dx_wr <= 1'b1;
        dx_slot <= s;
        dx_idx <= i;
        dx_wdata <= d;
        @(posedge sys_clk);
        dx_wr <= 1'b0;
        dx_wdata <= ~d;
    endtask : wr_byte

    // Only configured slots are addressed, gaps stay empty
    task send_tot(input logic [3:0] s, input logic [7:0] ctl,
                  input logic [7:0] mode);
        wr_byte(s, 3'h0, ctl);
        wr_byte(s, 3'h1, mode);
    endtask : send_tot

    // Values already in SI units, most significant byte first
    task send_float(input logic [3:0] s, input logic [31:0] v,
                    input logic [7:0] st);
        for (int k = 0; k < 4; k++)
            wr_byte(s, 3'(k), v[31 - 8 * k -: 8]);
        wr_byte(s, 3'h4, st);
    endtask : send_float

    task send_disc(input logic [3:0] s, input logic [7:0] cmd,
                   input logic [7:0] st);
        wr_byte(s, 3'h0, cmd);
        wr_byte(s, 3'h1, st);
    endtask : send_disc

    task commit;
        @(posedge sys_clk);
        dx_commit <= 1'b1;
        @(posedge sys_clk);
        dx_commit <= 1'b0;
    endtask : commit

    task rd_byte(input logic [3:0] s, input logic [2:0] i,
                 output logic [7:0] d);
        d = 8'hXX;
        @(posedge sys_clk);
        dx_rd <= 1'b1;
        dx_slot <= s;
        dx_idx <= i;
        @(posedge sys_clk);
        dx_rd <= 1'b0;
        for (int n = 0; n < 4; n++)
        begin
            @(posedge sys_clk);
            if (dx_rvalid === 1'b1)
            begin
                d = dx_rdata;
                break;
            end
        end
    endtask : rd_byte
endmodule : fcsp_master_model

// file: bench/fcsp_top_tb.sv
`timescale 1ns/1ps
module fcsp_top_tb
    import fcsp_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, dens_value, ext_temp_value, rd;
    logic pready, pslverr, dx_wr, dx_commit, dx_rd, dx_rvalid, er;
    logic [3:0] dx_slot, act;
    logic [2:0] dx_idx, tot_clear, tot_preset;
    logic [7:0] dx_wdata, dx_rdata, dens_status, ext_temp_status;
    logic [2:0][31:0] tot_value = '0;
    logic [2:0][7:0] tot_status = '0;
    logic [2:0][1:0] total_count_mode;
    logic switch_state = 1'b0;
    logic empty_pipe = 1'b0;
    logic low_flow_cut = 1'b0;
    logic verify_result = 1'b0;
    logic flow_override, verify_start;
    logic hw_addr_sel = 1'b0;
    logic [6:0] hw_addr = 7'h05;
    logic [6:0] bus_address;
    logic [15:0] chs [4] = '{16'h037D, 16'h037E, 16'h037F, 16'h0596};
    logic [7:0] ctl [4] = '{8'h01, 8'h02, 8'h03, 8'h00};
    logic [7:0] c12 [3] = '{8'h01, 8'h00, 8'h01};
    logic [7:0] c13 [3] = '{8'h01, 8'h02, 8'h00};
    logic [1:0] e_do [3] = '{2'b11, 2'b01, 2'b10};
    int err_count = 0;
    int checks_done = 0;
    int clr_hits = 0;
    int pre_hits = 0;
    int stray = 0;

    always #2.5 sys_clk = ~sys_clk;

    fcsp_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dx_wr(dx_wr), .dx_slot(dx_slot),
        .dx_idx(dx_idx), .dx_wdata(dx_wdata), .dx_commit(dx_commit),
        .dx_rd(dx_rd), .dx_rdata(dx_rdata), .dx_rvalid(dx_rvalid),
        .tot_value(tot_value), .tot_status(tot_status),
        .total_count_mode(total_count_mode), .tot_clear(tot_clear),
        .tot_preset(tot_preset), .dens_value(dens_value),
        .dens_status(dens_status), .ext_temp_value(ext_temp_value),
        .ext_temp_status(ext_temp_status), .switch_state(switch_state),
        .empty_pipe(empty_pipe), .low_flow_cut(low_flow_cut),
        .verify_result(verify_result), .flow_override(flow_override),
        .verify_start(verify_start), .hw_addr_sel(hw_addr_sel),
        .hw_addr(hw_addr), .bus_address(bus_address));

    fcsp_master_model mdl (.sys_clk(sys_clk), .dx_wr(dx_wr),
        .dx_slot(dx_slot), .dx_idx(dx_idx), .dx_wdata(dx_wdata),
        .dx_commit(dx_commit), .dx_rd(dx_rd), .dx_rdata(dx_rdata),
        .dx_rvalid(dx_rvalid));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task chk(input string nm, input logic [31:0] exp,
             input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] r, output logic e);
        r = 32'hXXXXXXXX;
        e = 1'bX;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (int n = 0; n < 8; n++)
        begin
            @(posedge sys_clk);
            if (pready === 1'b1)
            begin
                r = prdata;
                e = pslverr;
                break;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wreg(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, er);
        chk("write error flag", 32'h0, {31'h0, er});
    endtask : wreg

    task rreg(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0, rd, er);
        chk(nm, exp, rd);
        chk("read error flag", 32'h0, {31'h0, er});
    endtask : rreg

    task rchk(input int s, input int i, input logic [7:0] exp,
              input string nm);
        logic [7:0] b;
        mdl.rd_byte(4'(s), 3'(i), b);
        chk(nm, {24'h0, exp}, {24'h0, b});
    endtask : rchk

    task exchange;
        mdl.commit();
        @(posedge sys_clk);
        #1;
    endtask : exchange

    task tend(input string nm);
        $display("Test %s finished", nm);
    endtask : tend

    task stop_test;
        $display("Checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    // Clear and preset pulse counting
    always @(posedge sys_clk)
    begin
        if (rst_n)
        begin
            if (tot_clear == 3'b010)
                clr_hits++;
            else if (tot_clear !== 3'b000)
                stray++;
            if (tot_preset == 3'b010)
                pre_hits++;
            else if (tot_preset !== 3'b000)
                stray++;
        end
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("modes", 32'h0, {26'h0, total_count_mode});
        chk("bus address", 32'h7E, {25'h0, bus_address});
        rreg(REG_DSTATE1_CH, 32'h037E, "ch1");
        rreg(REG_DSTATE2_CH, 32'h037F, "ch2");
        rreg(REG_SW_ADDR, 32'h7E, "sw addr");
        rreg(REG_ADDR_STAT, 32'h7E, "addr status");
        rreg(REG_MODE_STAT, 32'h0, "mode status");
        wreg(REG_COMP_CH, 32'h0);
        rreg(REG_COMP_CH, 32'h013302DB, "comp ch");
        rreg(REG_DCMD_CH, 32'h0595037B, "cmd ch");
        apb(1'b0, 8'h1C, 32'h0, rd, er);
        chk("unmapped error", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        tend("reset");
        for (int t = 0; t < 3; t++)
            for (int m = 0; m < 5; m++)
            begin
                mdl.send_tot(4'(5 + t), 8'h00, 8'(m));
                exchange();
                chk("mode", 32'(m > 3 ? 3 : m), 32'(total_count_mode[t]));
            end
        rreg(REG_MODE_STAT, 32'h3F, "mode status");
        tend("modes");
        for (int k = 0; k < 4; k++)
        begin
            mdl.send_tot(4'h6, ctl[k], 8'h03);
            exchange();
        end
        repeat (2) @(posedge sys_clk);
        chk("clear pulses", 32'd1, 32'(clr_hits));
        chk("preset pulses", 32'd1, 32'(pre_hits));
        chk("stray pulses", 32'd0, 32'(stray));
        @(posedge sys_clk);
        tot_value <= {32'hC2C80000, 32'h3F800000, 32'h447A0000};
        tot_status <= {8'h80, 8'h4C, 8'h10};
        exchange();
        for (int t = 0; t < 3; t++)
            for (int i = 0; i < 5; i++)
                rchk(5 + t, i, i < 4 ? tot_value[t][31 - 8 * i -: 8]
                     : tot_status[t], "total byte");
        rchk(14, 0, 8'h00, "unused slot");
        tend("totalizers");
        mdl.send_float(4'h8, 32'h44798CCD, 8'h80);
        mdl.send_float(4'h9, 32'h43929333, 8'h4C);
        exchange();
        chk("density", 32'h44798CCD, dens_value);
        chk("density status", 32'h80, {24'h0, dens_status});
        chk("temperature", 32'h43929333, ext_temp_value);
        chk("temp status", 32'h4C, {24'h0, ext_temp_status});
        tend("compensation");
        for (int p = 0; p < 2; p++)
            for (int k = 0; k < 4; k++)
            begin
                act = p ? 4'b1010 : 4'b0101;
                wreg(REG_DSTATE1_CH, {16'h0, chs[k]});
                wreg(REG_DSTATE2_CH, {16'h0, chs[3 - k]});
                {verify_result, low_flow_cut, empty_pipe, switch_state} <= act;
                exchange();
                rchk(10, 0, {7'h0, act[k]}, "state 1");
                rchk(10, 1, 8'h80, "status 1");
                rchk(11, 0, {7'h0, act[3 - k]}, "state 2");
            end
        wreg(REG_DSTATE1_CH, 32'h0001);
        exchange();
        rchk(10, 0, 8'h00, "unknown state");
        rchk(10, 1, 8'h00, "unknown status");
        tend("discrete inputs");
        for (int k = 0; k < 3; k++)
        begin
            mdl.send_disc(4'hC, c12[k], 8'h80);
            mdl.send_disc(4'hD, c13[k], 8'h80);
            exchange();
            chk("override", {31'h0, e_do[k][1]}, {31'h0, flow_override});
            chk("verify start", {31'h0, e_do[k][0]}, {31'h0, verify_start});
        end
        tend("discrete outputs");
        wreg(REG_SW_ADDR, 32'h10);
        wreg(REG_SW_ADDR, 32'h7F);
        rreg(REG_SW_ADDR, 32'h10, "sw addr");
        chk("bus address", 32'h10, {25'h0, bus_address});
        @(posedge sys_clk);
        hw_addr_sel <= 1'b1;
        hw_addr <= 7'h33;
        wreg(REG_SW_ADDR, 32'h20);
        rreg(REG_SW_ADDR, 32'h10, "sw addr locked");
        rreg(REG_ADDR_STAT, 32'h133, "addr status");
        chk("hw address", 32'h33, {25'h0, bus_address});
        @(posedge sys_clk);
        hw_addr_sel <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("bus address", 32'h10, {25'h0, bus_address});
        tend("address");
        stop_test();
    end

    initial
    begin
        #200000;
        err_count++;
        $display("Watchdog expired");
        stop_test();
    end
endmodule : fcsp_top_tb
